// *** logic/rbs_read_seq.sv ***
// read port sequencer: multiple loads, swaps and table walks as bus beats
//
// Notes on behaviour
// - six words at word 0: three full doublewords
// - ordered six from word 1: alternating word beats
// - normal six from word 1: INCR4, all flagged
// - six words at word 2: three full doublewords
// - six from words 3-7 split, wrap to 0x00
// - ordered seven from 0: word beats, low first
// - normal seven from 0: INCR4, last flagged
// - ordered seven from 1: alternating word beats
// - normal seven from 1: INCR4, first flagged
// - seven from words 2-7 split at region end
// - eight from word 0: one INCR4 burst
// - eight from words 1-7 split at region
// - long loads: region end, then from 0x00
// - middle sequence is eight words from 0x00
// - sixteen from 0: two eight-word sequences
// - cachable swap write goes to write port
// - noncachable swap writes on read port, direction high
// - table walk: single word read, lane by bit2
// - overread flag only for normal memory overreads
// - sideband carries memory type and shareable bit
`timescale 1ns/1ps
`include "rbs_map.svh"
module rbs_read_seq
  import rbs_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic REQ_VALID_I,
  input wire logic [1:0] REQ_OP_I,
  input wire logic [31:0] REQ_ADDR_I,
  input wire logic [4:0] REQ_WORDS_I,
  input wire logic REQ_BYTE_I,
  input wire logic REQ_CACHABLE_I,
  input wire logic [2:0] MEM_TYPE_I,
  input wire logic MEM_SHARE_I,
  input wire logic RD_READY_I,
  output logic [1:0] RD_TRANSFER_TYPE_O,
  output logic [31:0] RD_BUS_ADDRESS_O,
  output logic [2:0] RD_BURST_TYPE_O,
  output logic [2:0] RD_TRANSFER_SIZE_O,
  output logic [7:0] RD_BYTE_STROBES_O,
  output logic RD_UNALIGNED_OVERREAD_FLAG_O,
  output logic RD_PORT_WRITE_DIRECTION_O,
  output logic [3:0] RD_MEMORY_ATTRIBUTE_SIDEBAND_O,
  output logic WR_STORE_REQ_O,
  output logic [31:0] WR_STORE_ADDR_O,
  output logic WR_STORE_BYTE_O,
  output logic BUSY_O,
  output logic DONE_O
);

  ////////////////////////////////////////////////////////////////////////////
  rbs_state_e state_r;
  rbs_state_e state_nxt;
  logic [1:0] tr_r;
  logic [1:0] tr_nxt;
  logic [31:0] ad_r;
  logic [31:0] ad_nxt;
  logic [2:0] bu_r;
  logic [2:0] bu_nxt;
  logic [2:0] sz_r;
  logic [2:0] sz_nxt;
  rbs_single_byte_store_t st_r;
  rbs_single_byte_store_t st_nxt;
  logic fl_r;
  logic fl_nxt;
  logic wr_r;
  logic wr_nxt;
  logic [3:0] sb_r;
  logic [26:0] base_r;
  logic [2:0] word_r;
  logic [3:0] seg_left_r;
  logic [4:0] tot_r;
  logic wide_r;
  logic ovr_r;
  logic all_r;
  logic [2:0] seg_bu_r;
  logic sw_cach_r;
  logic sw_byte_r;

  logic start;
  logic start_ml;
  logic start_sw;
  logic adv;
  logic more;
  logic beat_go;
  logic seg_new;
  logic [4:0] words_eff;
  logic [3:0] room;
  logic [2:0] p_word;
  logic [3:0] p_cnt;
  logic p_strict;
  logic p_wide;
  logic p_ovr;
  logic p_all;
  logic [3:0] p_beats;
  logic [2:0] p_burst;
  logic [4:0] tot_after;
  logic [2:0] cw;
  logic [3:0] sl;
  logic bw;
  logic bo;
  logic ba;
  logic [2:0] bb;
  logic [26:0] bbase;
  logic [3:0] used;
  rbs_single_byte_store_t narrow_single_byte_store;
  rbs_single_byte_store_t sw_single_byte_store;
  rbs_single_byte_store_t b_single_byte_store;

  ////////////////////////////////////////////////////////////////////////////
  // request decode and sequence cursor
  assign start = (state_r == RBS_IDLE) && REQ_VALID_I;
  assign start_ml = start && (REQ_OP_I != `RBS_OP_SWAP);
  assign start_sw = start && (REQ_OP_I == `RBS_OP_SWAP);
  // an address phase ends only on an edge with ready high
  assign adv = (tr_r != `RBS_TR_IDLE) && RD_READY_I;
  assign more = (seg_left_r != 4'h0) || (tot_r != 5'h00);
  assign beat_go = start_ml || ((state_r == RBS_LOAD) && adv && more);
  assign seg_new = start_ml || (seg_left_r == 4'h0);

  always_comb begin
    words_eff = (REQ_OP_I == `RBS_OP_WALK) ? `RBS_WALK_WORDS : REQ_WORDS_I;
    room = `RBS_REGION_WORDS - {1'b0, REQ_ADDR_I[4:2]};
    p_word = 3'h0;
    p_cnt = `RBS_REGION_WORDS;
    tot_after = 5'h00;
    p_strict = (sb_r[3:1] == `RBS_MT_SO) || (sb_r[3:1] == `RBS_MT_DEV);
    if (start_ml) begin
      // first part stops at region end
      p_word = REQ_ADDR_I[4:2];
      p_cnt = (words_eff < {1'b0, room}) ? words_eff[3:0] : room;
      tot_after = words_eff - {1'b0, p_cnt};
      p_strict = (MEM_TYPE_I == `RBS_MT_SO) || (MEM_TYPE_I == `RBS_MT_DEV);
    end else begin
      // later parts from offset zero, eight at most
      p_cnt = (tot_r > `RBS_REGION_WORDS5) ? `RBS_REGION_WORDS : tot_r[3:0];
      tot_after = tot_r - {1'b0, p_cnt};
    end
  end

  rbs_seg_plan u_plan (
    .word_i(p_word),
    .cnt_i(p_cnt),
    .strict_i(p_strict),
    .wide_o(p_wide),
    .ovr_o(p_ovr),
    .all_o(p_all),
    .beats_o(p_beats),
    .burst_o(p_burst)
  );

  ////////////////////////////////////////////////////////////////////////////
  // one beat from the cursor
  always_comb begin
    cw = seg_new ? p_word : word_r;
    sl = seg_new ? p_cnt : seg_left_r;
    bw = seg_new ? p_wide : wide_r;
    bo = seg_new ? p_ovr : ovr_r;
    ba = seg_new ? p_all : all_r;
    bb = seg_new ? p_burst : seg_bu_r;
    // wrap stays in the same region
    bbase = start_ml ? REQ_ADDR_I[31:5] : base_r;
    if (bw && !cw[0] && (sl > `RBS_ONE_WORD)) begin
      used = `RBS_TWO_WORDS;
    end else begin
      used = `RBS_ONE_WORD;
    end
  end

  rbs_lane_single_byte_store u_beat_lane (
    .addr_i({cw[0], 2'b00}),
    .byte_i(1'b0),
    .single_byte_store_o(narrow_single_byte_store)
  );

  rbs_lane_single_byte_store u_swap_lane (
    .addr_i(REQ_ADDR_I[2:0]),
    .byte_i(REQ_BYTE_I),
    .single_byte_store_o(sw_single_byte_store)
  );

  always_comb begin
    if (!bw) begin
      b_single_byte_store = narrow_single_byte_store;
    end else if (cw[0]) begin
      b_single_byte_store = `RBS_ST_HI;
    end else if (sl == `RBS_ONE_WORD) begin
      // lone last word: lower half only
      b_single_byte_store = `RBS_ST_LO;
    end else begin
      b_single_byte_store = `RBS_ST_ALL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next values of the address phase
  always_comb begin
    tr_nxt = tr_r;
    ad_nxt = ad_r;
    bu_nxt = bu_r;
    sz_nxt = sz_r;
    st_nxt = st_r;
    fl_nxt = fl_r;
    wr_nxt = wr_r;
    if (beat_go) begin
      tr_nxt = seg_new ? `RBS_TR_NSEQ : `RBS_TR_SEQ;
      ad_nxt = bw ? {bbase, cw[2:1], 3'b000} : {bbase, cw, 2'b00};
      bu_nxt = bb;
      sz_nxt = bw ? `RBS_SZ_DWORD : `RBS_SZ_WORD;
      st_nxt = b_single_byte_store;
      // flag beats that fetch bytes beyond the load, or every beat when both ends are partial
      fl_nxt = bo && (ba || (b_single_byte_store != `RBS_ST_ALL));
      wr_nxt = 1'b0;
    end else if (start_sw) begin
      tr_nxt = `RBS_TR_NSEQ;
      ad_nxt = REQ_ADDR_I;
      bu_nxt = `RBS_BU_SINGLE;
      sz_nxt = REQ_BYTE_I ? `RBS_SZ_BYTE : `RBS_SZ_WORD;
      st_nxt = sw_single_byte_store;
      fl_nxt = 1'b0;
      wr_nxt = 1'b0;
    end else if ((state_r == RBS_SWPR) && adv && !sw_cach_r) begin
      // write half reuses the read port
      tr_nxt = `RBS_TR_NSEQ;
      wr_nxt = 1'b1;
    end else if (adv) begin
      tr_nxt = `RBS_TR_IDLE;
      bu_nxt = `RBS_BU_SINGLE;
      st_nxt = `RBS_ST_NONE;
      fl_nxt = 1'b0;
      wr_nxt = 1'b0;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RBS_IDLE: begin
        if (start_ml) begin
          state_nxt = RBS_LOAD;
        end else if (start_sw) begin
          state_nxt = RBS_SWPR;
        end
      end
      RBS_LOAD: begin
        if (adv && !more) begin
          state_nxt = RBS_IDLE;
        end
      end
      RBS_SWPR: begin
        if (adv) begin
          state_nxt = sw_cach_r ? RBS_IDLE : RBS_SWPW;
        end
      end
      RBS_SWPW: begin
        if (adv) begin
          state_nxt = RBS_IDLE;
        end
      end
      default: begin
        state_nxt = RBS_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state_r <= RBS_IDLE;
      BUSY_O <= 1'b0;
      DONE_O <= 1'b0;
    end else begin
      state_r <= state_nxt;
      BUSY_O <= (state_nxt != RBS_IDLE);
      DONE_O <= (state_r != RBS_IDLE) && (state_nxt == RBS_IDLE);
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      tr_r <= `RBS_TR_IDLE;
      ad_r <= 32'h0000_0000;
      bu_r <= `RBS_BU_SINGLE;
      sz_r <= `RBS_SZ_WORD;
      st_r <= `RBS_ST_NONE;
      fl_r <= 1'b0;
      wr_r <= 1'b0;
    end else begin
      tr_r <= tr_nxt;
      ad_r <= ad_nxt;
      bu_r <= bu_nxt;
      sz_r <= sz_nxt;
      st_r <= st_nxt;
      fl_r <= fl_nxt;
      wr_r <= wr_nxt;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      base_r <= 27'h000_0000;
      word_r <= 3'h0;
      seg_left_r <= 4'h0;
      tot_r <= 5'h00;
      wide_r <= 1'b0;
      ovr_r <= 1'b0;
      all_r <= 1'b0;
      seg_bu_r <= `RBS_BU_SINGLE;
    end else if (beat_go) begin
      base_r <= bbase;
      word_r <= cw + used[2:0];
      seg_left_r <= sl - used;
      if (seg_new) begin
        tot_r <= tot_after;
        wide_r <= p_wide;
        ovr_r <= p_ovr;
        all_r <= p_all;
        seg_bu_r <= p_burst;
      end
    end
  end

  // attributes held for the whole operation
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      sb_r <= 4'h0;
      sw_cach_r <= 1'b0;
      sw_byte_r <= 1'b0;
    end else if (start) begin
      sb_r <= {MEM_TYPE_I, MEM_SHARE_I};
      sw_cach_r <= REQ_CACHABLE_I;
      sw_byte_r <= REQ_BYTE_I;
    end
  end

  // cachable swap store handed to the write port
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      WR_STORE_REQ_O <= 1'b0;
      WR_STORE_ADDR_O <= 32'h0000_0000;
      WR_STORE_BYTE_O <= 1'b0;
    end else begin
      WR_STORE_REQ_O <= (state_r == RBS_SWPR) && adv && sw_cach_r;
      if ((state_r == RBS_SWPR) && adv && sw_cach_r) begin
        WR_STORE_ADDR_O <= ad_r;
        WR_STORE_BYTE_O <= sw_byte_r;
      end
    end
  end

  assign RD_TRANSFER_TYPE_O = tr_r;
  assign RD_BUS_ADDRESS_O = ad_r;
  assign RD_BURST_TYPE_O = bu_r;
  assign RD_TRANSFER_SIZE_O = sz_r;
  assign RD_BYTE_STROBES_O = st_r;
  assign RD_UNALIGNED_OVERREAD_FLAG_O = fl_r;
  assign RD_PORT_WRITE_DIRECTION_O = wr_r;
  assign RD_MEMORY_ATTRIBUTE_SIDEBAND_O = sb_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  full_dword_a: assert property (
    (tr_r != `RBS_TR_IDLE) && (sz_r == `RBS_SZ_DWORD) && !fl_r |-> st_r == `RBS_ST_ALL)
    else $error("unflagged doubleword beat without full strobes");

  narrow_lane_a: assert property (
    (tr_r != `RBS_TR_IDLE) && (sz_r == `RBS_SZ_WORD)
    |-> st_r == (ad_r[2] ? `RBS_ST_HI : `RBS_ST_LO))
    else $error("word beat on wrong byte lanes");

  ordered_full_a: assert property (
    (state_r == RBS_LOAD) && (tr_r != `RBS_TR_IDLE) && (sz_r == `RBS_SZ_DWORD)
    && ((sb_r[3:1] == `RBS_MT_SO) || (sb_r[3:1] == `RBS_MT_DEV))
    |-> st_r == `RBS_ST_ALL && !fl_r)
    else $error("partial doubleword to ordered memory");

  overread_normal_a: assert property (
    fl_r |-> (state_r == RBS_LOAD) && (sz_r == `RBS_SZ_DWORD)
    && (sb_r[3:1] != `RBS_MT_SO) && (sb_r[3:1] != `RBS_MT_DEV))
    else $error("overread flag outside a normal memory load");

  seq_forward_a: assert property (
    (tr_r == `RBS_TR_SEQ) && $changed(ad_r)
    |-> ad_r[4:0] > $past(ad_r[4:0]) && ad_r[31:5] == $past(ad_r[31:5]))
    else $error("sequential beat left its region or went back");

  wrap_zero_a: assert property (
    (state_r == RBS_LOAD) && adv && (seg_left_r == 4'h0) && (tot_r != 5'h00)
    |=> tr_r == `RBS_TR_NSEQ && ad_r[4:0] == `RBS_OFS_ZERO
    && ad_r[31:5] == $past(ad_r[31:5]))
    else $error("follow-on sequence not at region start");

  swap_write_a: assert property (
    $rose(wr_r) |-> tr_r == `RBS_TR_NSEQ && $past(tr_r) == `RBS_TR_NSEQ
    && ad_r == $past(ad_r) && !sw_cach_r ##1 wr_r == !$past(RD_READY_I))
    else $error("read port write not paired with swap read");

  swap_store_a: assert property (
    (state_r == RBS_SWPR) && adv && sw_cach_r
    |=> WR_STORE_REQ_O && !wr_r && tr_r == `RBS_TR_IDLE ##1 !WR_STORE_REQ_O)
    else $error("cachable swap store not sent to write port");

  walk_single_a: assert property (
    start && (REQ_OP_I == `RBS_OP_WALK)
    |=> tr_r == `RBS_TR_NSEQ && bu_r == `RBS_BU_SINGLE && sz_r == `RBS_SZ_WORD)
    else $error("table walk not a single word read");

endmodule

// *** logic/rbs_map.svh ***
// constant map for the read port burst sequencer
`ifndef RBS_MAP_SVH
`define RBS_MAP_SVH
`define RBS_TR_IDLE 2'h0
`define RBS_TR_NSEQ 2'h2
`define RBS_TR_SEQ 2'h3
`define RBS_BU_SINGLE 3'h0
`define RBS_BU_INCR 3'h1
`define RBS_BU_INCR4 3'h3
`define RBS_SZ_BYTE 3'h0
`define RBS_SZ_WORD 3'h2
`define RBS_SZ_DWORD 3'h3
`define RBS_ST_ALL 8'hff
`define RBS_ST_LO 8'h0f
`define RBS_ST_HI 8'hf0
`define RBS_ST_NONE 8'h00
`define RBS_ST_BYTE0 8'h01
`define RBS_MT_SO 3'h0
`define RBS_MT_DEV 3'h1
`define RBS_OP_MLOAD 2'h0
`define RBS_OP_SWAP 2'h1
`define RBS_OP_WALK 2'h2
`define RBS_REGION_WORDS 4'h8
`define RBS_REGION_WORDS5 5'h08
`define RBS_INCR4_BEATS 4'h4
`define RBS_ONE_WORD 4'h1
`define RBS_TWO_WORDS 4'h2
`define RBS_WALK_WORDS 5'h01
`define RBS_OFS_ZERO 5'h00
`endif

// *** logic/rbs_pkg.sv ***
// types shared by the read port burst sequencer
package rbs_pkg;
  typedef enum logic [1:0] {RBS_IDLE, RBS_LOAD, RBS_SWPR, RBS_SWPW} rbs_state_e;
  typedef logic [7:0] rbs_single_byte_store_t;
endpackage

// *** logic/rbs_lane_single_byte_store.sv ***
// byte lane strobes for a single word or byte access
`timescale 1ns/1ps
`include "rbs_map.svh"
module rbs_lane_single_byte_store
  import rbs_pkg::*;
(
  input wire logic [2:0] addr_i,
  input wire logic byte_i,
  output rbs_single_byte_store_t single_byte_store_o
);
  always_comb begin
    if (byte_i) begin
      single_byte_store_o = rbs_single_byte_store_t'(`RBS_ST_BYTE0 << addr_i);
    end else if (addr_i[2]) begin
      single_byte_store_o = `RBS_ST_HI;
    end else begin
      single_byte_store_o = `RBS_ST_LO;
    end
  end
endmodule

// *** logic/rbs_seg_plan.sv ***
// shape of one sequence of at most eight words inside a 32-byte region
`timescale 1ns/1ps
`include "rbs_map.svh"
module rbs_seg_plan (
  input wire logic [2:0] word_i,
  input wire logic [3:0] cnt_i,
  input wire logic strict_i,
  output logic wide_o,
  output logic ovr_o,
  output logic all_o,
  output logic [3:0] beats_o,
  output logic [2:0] burst_o
);
  logic even;
  logic [3:0] last;
  always_comb begin
    even = !word_i[0] && !cnt_i[0];
    last = {1'b0, word_i} + cnt_i - `RBS_ONE_WORD;
    wide_o = (cnt_i != `RBS_ONE_WORD) && (even || !strict_i);
    ovr_o = wide_o && !even;
    // both ends partial: overread flagged on every beat
    all_o = word_i[0] && !last[0];
    if (wide_o) begin
      beats_o = {1'b0, last[3:1]} - {2'b00, word_i[2:1]} + `RBS_ONE_WORD;
    end else begin
      beats_o = cnt_i;
    end
    if (beats_o == `RBS_ONE_WORD) begin
      burst_o = `RBS_BU_SINGLE;
    end else if (beats_o == `RBS_INCR4_BEATS) begin
      burst_o = `RBS_BU_INCR4;
    end else begin
      burst_o = `RBS_BU_INCR;
    end
  end
endmodule

// *** dv/rbs_slave_model.sv ***
// read port slave model with selectable wait states
`timescale 1ns/1ps
module rbs_slave_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  output logic ready_o
);
  logic [1:0] wait_r;
  ////////////////////////////////////////////////////////////
  // slow: ready one edge in four, beats must hold meanwhile
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_r <= 2'h0;
      ready_o <= 1'b1;
    end else begin
      wait_r <= wait_r + 2'h1;
      ready_o <= !slow_i || (wait_r == 2'h2);
    end
  end
endmodule

// *** dv/tb_top.sv ***
// self-checking bench for the read port sequencer
`timescale 1ns/1ps
`include "rbs_map.svh"
module tb_top;
  import rbs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic vld = 1'b0;
  logic [1:0] op = 2'h0;
  logic [31:0] adr = 32'h0000_0000;
  logic [4:0] wds = 5'h00;
  logic byt = 1'b0;
  logic cch = 1'b0;
  logic [2:0] mt = 3'h0;
  logic shr = 1'b0;
  logic slow = 1'b0;
  logic rdy, fl, wd, sreq, sbyte, busy, done;
  logic [1:0] tt;
  logic [31:0] ba, sa;
  logic [2:0] bt, sz;
  logic [7:0] sb;
  logic [3:0] sd;
  logic [53:0] q_bus[$];
  logic [32:0] q_st[$];
  logic [31:0] rnd = 32'h0001_2539;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  int reqs = 0;
  int dones = 0;
  int k;
  always #5 clk = ~clk;
  rbs_read_seq rbs_read_seq_inst (.SYS_CLK_I(clk), .SYS_RST_I(rst), .REQ_VALID_I(vld),
    .REQ_OP_I(op), .REQ_ADDR_I(adr), .REQ_WORDS_I(wds), .REQ_BYTE_I(byt),
    .REQ_CACHABLE_I(cch), .MEM_TYPE_I(mt), .MEM_SHARE_I(shr), .RD_READY_I(rdy),
    .RD_TRANSFER_TYPE_O(tt), .RD_BUS_ADDRESS_O(ba), .RD_BURST_TYPE_O(bt),
    .RD_TRANSFER_SIZE_O(sz), .RD_BYTE_STROBES_O(sb), .RD_UNALIGNED_OVERREAD_FLAG_O(fl),
    .RD_PORT_WRITE_DIRECTION_O(wd), .RD_MEMORY_ATTRIBUTE_SIDEBAND_O(sd),
    .WR_STORE_REQ_O(sreq), .WR_STORE_ADDR_O(sa), .WR_STORE_BYTE_O(sbyte),
    .BUSY_O(busy), .DONE_O(done));
  rbs_slave_model rbs_slave_model_inst (.clk_i(clk), .rst_i(rst), .slow_i(slow),
    .ready_o(rdy));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [2:0] bt_of(input int nb);
    return (nb == 1) ? `RBS_BU_SINGLE : (nb == 4) ? `RBS_BU_INCR4 : `RBS_BU_INCR;
  endfunction
  task automatic tally(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_beat(input logic [53:0] got, input logic [53:0] exp);
    tally({10'h000, got}, {10'h000, exp});
  endtask
  task automatic cmp_store(input logic [32:0] got, input logic [32:0] exp);
    tally({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask
  task automatic cmp_count(input logic [31:0] got, input logic [31:0] exp);
    tally({32'h0000_0000, got}, {32'h0000_0000, exp});
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic push(input logic [1:0] t, input logic [31:0] a, input logic [2:0] b,
      input logic [2:0] s, input logic [7:0] m, input logic f, input logic w);
    // sideband is memory type and shareable bit
    q_bus.push_back({t, a, b, s, m, f, w, mt, shr});
  endtask
  // requests held while busy are refused; refusal keeps junk up one busy edge
  task automatic issue(input logic [1:0] o, input int n, input logic refuse);
    int i;
    i = 0;
    while (busy !== 1'b0 && i < 200) begin
      @(posedge clk);
      #1;
      i++;
    end
    vld = 1'b1;
    op = o;
    wds = n[4:0];
    @(posedge clk);
    #1;
    reqs++;
    cmp_count(32'(busy), 32'h0000_0001); // 22
    if (refuse) begin
      op = `RBS_OP_WALK;
      adr = ~adr;
      @(posedge clk);
      #1;
    end
    vld = 1'b0;
    if (refuse) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic load(input int n, input int w, input logic st);
    int s, c, left, j, nb;
    logic [31:0] base;
    logic [7:0] m;
    logic dw, both;
    rnd = lfsr(rnd);
    mt = st ? {2'h0, rnd[0]} : {rnd[2], 1'b1, rnd[1]};
    shr = rnd[3];
    slow = rnd[4];
    adr = {rnd[31:5], w[2:0], 2'h0};
    base = {adr[31:5], 5'h00};
    s = w;
    left = n;
    // region end first, then from 0x00
    while (left > 0) begin
      c = (8 - s < left) ? 8 - s : left;
      dw = (s % 2 == 0 && c % 2 == 0) || (!st && c > 1);
      both = (s % 2 == 1) && ((s + c) % 2 == 1);
      nb = dw ? (s + c + 1) / 2 - s / 2 : c;
      for (j = 0; j < nb; j++) begin
        if (dw) begin
          m = (j == 0 && s % 2 == 1) ? 8'hf0 : 8'hff;
          if (j == nb - 1 && (s + c) % 2 == 1) m = m & 8'h0f;
          push((j != 0) ? `RBS_TR_SEQ : `RBS_TR_NSEQ, base + 32'(8 * (s / 2 + j)),
            bt_of(nb), `RBS_SZ_DWORD, m, both || m != 8'hff, 1'b0);
        end else begin
          // word beats, lanes by address bit 2
          push((j != 0) ? `RBS_TR_SEQ : `RBS_TR_NSEQ, base + 32'(4 * (s + j)),
            bt_of(nb), `RBS_SZ_WORD, ((s + j) % 2 == 1) ? 8'hf0 : 8'h0f, 1'b0, 1'b0);
        end
      end
      left -= c;
      s = 0;
    end
    issue(`RBS_OP_MLOAD, n, rnd[5]);
  endtask
  task automatic swap(input logic b, input logic ca);
    logic [7:0] m;
    rnd = lfsr(rnd);
    mt = rnd[2:0];
    shr = rnd[3];
    slow = rnd[4];
    adr = b ? rnd : {rnd[31:2], 2'h0};
    byt = b;
    cch = ca;
    m = b ? 8'h01 << adr[2:0] : (adr[2] ? 8'hf0 : 8'h0f);
    push(`RBS_TR_NSEQ, adr, `RBS_BU_SINGLE, b ? `RBS_SZ_BYTE : `RBS_SZ_WORD, m, 1'b0, 1'b0);
    // cachable write leaves on the store port, else a read port write
    if (ca) q_st.push_back({adr, b});
    else push(`RBS_TR_NSEQ, adr, `RBS_BU_SINGLE, b ? `RBS_SZ_BYTE : `RBS_SZ_WORD, m, 1'b0, 1'b1);
    issue(`RBS_OP_SWAP, 1, rnd[5]);
  endtask
  task automatic walk();
    rnd = lfsr(rnd);
    mt = rnd[2:0];
    shr = rnd[3];
    slow = rnd[4];
    adr = {rnd[31:2], 2'h0};
    // single word read, lanes by bit 2
    push(`RBS_TR_NSEQ, adr, `RBS_BU_SINGLE, `RBS_SZ_WORD, adr[2] ? 8'hf0 : 8'h0f, 1'b0, 1'b0);
    issue(`RBS_OP_WALK, 1, rnd[6]);
  endtask
  ////////////////////////////////////////////////////////////
  // each accepted beat takes the oldest note
  always @(posedge clk) begin
    if (!rst) begin
      cycles++;
      if (done === 1'b1) dones++;
      if (tt !== `RBS_TR_IDLE && rdy === 1'b1)
        cmp_beat({tt, ba, bt, sz, sb, fl, wd, sd}, q_bus.size() ? q_bus.pop_front() : '1); // 22
      if (sreq === 1'b1)
        cmp_store({sa, sbyte}, q_st.size() ? q_st.pop_front() : '1);
      if (cycles == 30000) begin
        fails++;
        final_report();
      end
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    @(posedge clk);
    #1;
    cmp_beat({tt, ba, bt, sz, sb, fl, wd, sd}, {`RBS_TR_IDLE, 32'h0000_0000, `RBS_BU_SINGLE,
      `RBS_SZ_WORD, `RBS_ST_NONE, 6'h00});
    for (k = 0; k < 176; k++) load(6 + k / 16, (k / 2) % 8, k[0]); // 15
    for (k = 0; k < 16; k++) swap(k[0], k[1]);
    for (k = 0; k < 8; k++) walk();
    repeat (60) @(posedge clk);
    #1;
    cmp_count(dones, reqs); // 22
    cmp_count(q_bus.size() + q_st.size(), 0); // 22
    final_report();
  end
endmodule
